// ===== sim/nbs_master_model.sv
// nbs_master_model: behavioural bus master facing the slave card.
// assumes the bench resolves wire levels from both parties' drives.
`timescale 1ns/1ps
module nbs_master_model (
  input wire logic i_core_clk,
  input wire logic i_ack_n,
  input wire logic [1:0] i_tm_n,
  input wire logic [31:0] i_ad_n,
  output logic o_start_n,
  output logic o_ack_n,
  output logic [1:0] o_tm_n,
  output logic [31:0] o_ad_n
);
  initial begin
    o_start_n = 1'b1;
    o_ack_n = 1'b1;
    o_tm_n = 2'b00;
    o_ad_n = 32'h0000_0000;
  end
  // released three-state lines show the inverse of their last level
  task automatic release_lines();
    o_tm_n = ~o_tm_n;
    o_ad_n = ~o_ad_n;
  endtask
  task automatic xfer(input logic [1:0] tm, input logic [31:0] a, input logic [31:0] d,
    output logic [1:0] st, output logic [31:0] rd, output int n);
    @(negedge i_core_clk);
    o_start_n = 1'b0;
    o_ack_n = 1'b1;
    o_tm_n = tm;
    o_ad_n = ~a;
    @(negedge i_core_clk);
    o_start_n = 1'b1;
    o_tm_n = ~o_tm_n;
    o_ad_n = tm[1] ? ~o_ad_n : ~d;
    // what is seen now stood in cycle 1; ack first shows at the start of cycle 2
    n = 1;
    #1;
    // bounded: the caller treats 300 as a hang
    while (i_ack_n !== 1'b0 && n < 300) begin
      @(negedge i_core_clk);
      #1;
      n++;
    end
    st = i_tm_n;
    rd = ~i_ad_n;
    @(negedge i_core_clk);
    release_lines();
  endtask
  task automatic attention(input logic [1:0] code, input logic [31:0] a);
    @(negedge i_core_clk);
    o_start_n = 1'b0;
    o_ack_n = 1'b0;
    o_tm_n = code;
    o_ad_n = ~a;
    @(negedge i_core_clk);
    o_start_n = 1'b1;
    o_ack_n = 1'b1;
    release_lines();
  endtask
endmodule // nbs_master_model

// ===== sim/nbs_slave_tb.sv
// nbs_slave_tb: self-checking bench for the slave card with a master model.
// assumes a 20 MHz bus clock and pull-ups on start and ack.
`timescale 1ns/1ps
module nbs_slave_tb;
  import nbs_pkg::*;
  logic clk, rst, ce, retry, tmo_en, host, m_start_n, m_ack_n, ack_w;
  logic s_ack_n, s_ack_oe, s_tm_oe, s_ad_oe, lock, bus_err, irq;
  logic [3:0] wait_c;
  logic [1:0] m_tm_n, s_tm_n, tm_w;
  logic [31:0] m_ad_n, s_ad_n, ad_w;
  logic [NBS_NMRQ_SLOTS-1:0] nmrq_n, slots;
  int n_errors, cmp_count;
  localparam logic [31:0] BASE = 32'hf900_0000;
  assign ack_w = (s_ack_oe ? s_ack_n : 1'b1) & m_ack_n;
  assign tm_w = s_tm_oe ? s_tm_n : m_tm_n;
  assign ad_w = s_ad_oe ? s_ad_n : m_ad_n;
  nbs_slave u_nbs_slave (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_slot_id(4'h9),
    .i_wait(wait_c), .i_retry(retry), .i_tmo_en(tmo_en), .i_host_txn(host),
    .i_start_n(m_start_n), .i_ack_n(ack_w), .i_tm_n(tm_w), .i_ad_n(ad_w), .i_nmrq_n(nmrq_n),
    .o_ack_n(s_ack_n), .o_ack_oe(s_ack_oe), .o_tm_n(s_tm_n), .o_tm_oe(s_tm_oe),
    .o_ad_n(s_ad_n), .o_ad_oe(s_ad_oe), .o_lock_active(lock), .o_bus_err(bus_err),
    .o_nmrq_irq(irq), .o_nmrq_slots(slots));
  nbs_master_model u_nbs_master_model (.i_core_clk(clk), .i_ack_n(ack_w), .i_tm_n(tm_w),
    .i_ad_n(ad_w), .o_start_n(m_start_n), .o_ack_n(m_ack_n), .o_tm_n(m_tm_n),
    .o_ad_n(m_ad_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic txn(input logic [1:0] tm, input logic [31:0] a, input logic [31:0] d,
    input logic [1:0] exp_st, input int exp_n, output logic [31:0] rd);
    logic [1:0] st;
    int n;
    u_nbs_master_model.xfer(tm, a, d, st, rd, n);
    if (n >= 300) begin
      n_errors++;
      $display("CHECK FAILED at %0t: no acknowledge", $time);
      final_report();
    end
    chk(32'(st), 32'(exp_st));
    chk(n, exp_n);
  endtask
  task automatic sc_lanes();
    logic [31:0] rd;
    txn(2'b01, BASE | 32'h4, 32'ha5c3_0f96, NBS_ST_DONE, 2, rd);
    wait_c = 4'h3;
    txn(2'b00, BASE | 32'h7, 32'h7e12_3456, NBS_ST_DONE, 5, rd);
    wait_c = 4'h0;
    txn(2'b01, BASE | 32'h5, 32'hffff_1234, NBS_ST_DONE, 2, rd);
    txn(2'b10, BASE | 32'h7, 32'h0, NBS_ST_DONE, 2, rd);
    chk(32'(rd[31:24]), 32'h7e);
    txn(2'b11, BASE | 32'h4, 32'h0, NBS_ST_DONE, 2, rd);
    chk(rd, 32'h7ec3_1234);
  endtask
  task automatic sc_status();
    logic [31:0] rd;
    retry = 1'b1;
    host = 1'b1;
    txn(2'b01, BASE | 32'h8, 32'h1111_2222, NBS_ST_RETRY, 2, rd);
    chk(32'(bus_err), 32'h1);
    retry = 1'b0;
    txn(2'b01, BASE | 32'h48, 32'h3333_4444, NBS_ST_ERR, 2, rd);
    chk(32'(bus_err), 32'h1);
    host = 1'b0;
    txn(2'b11, BASE | 32'h8, 32'h0, NBS_ST_DONE, 2, rd);
    chk(rd, 32'h0);
    tmo_en = 1'b1;
    txn(2'b11, 32'hf800_0000, 32'h0, NBS_ST_TMO, 256, rd);
    tmo_en = 1'b0;
  endtask
  task automatic sc_attention();
    u_nbs_master_model.attention(NBS_ATT_LOCK, BASE);
    chk(32'(s_ack_oe), 32'h0);
    @(negedge clk);
    chk(32'(lock), 32'h1);
    chk(32'(s_ack_oe), 32'h0);
    u_nbs_master_model.attention(NBS_ATT_NULL, BASE);
    @(negedge clk);
    chk(32'(lock), 32'h0);
  endtask
  task automatic sc_irq();
    nmrq_n = 6'h3b;
    repeat (6) @(negedge clk);
    chk(32'(slots), 32'h04);
    chk(32'(irq), 32'h1);
    nmrq_n = 6'h3f;
    repeat (6) @(negedge clk);
    chk(32'(irq), 32'h0);
  endtask
  task automatic sc_ce();
    ce = 1'b0;
    nmrq_n = 6'h3e;
    repeat (6) @(negedge clk);
    chk(32'(slots), 32'h00);
    ce = 1'b1;
    repeat (6) @(negedge clk);
    chk(32'(slots), 32'h01);
    nmrq_n = 6'h3f;
    repeat (6) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    n_errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    ce = 1'b1;
    retry = 1'b0;
    tmo_en = 1'b0;
    host = 1'b0;
    wait_c = 4'h0;
    nmrq_n = 6'h3f;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    sc_lanes();
    sc_status();
    sc_attention();
    sc_irq();
    sc_ce();
    final_report();
  end
endmodule // nbs_slave_tb

// ===== verilog/nbs_pkg.sv
// nbs_pkg: constants and carrier types for the single-transfer bus slave.
// assumes bus pins are synchronous to the core clock; pin levels kept as printed.
package nbs_pkg;
  // pin-level status codes on tm1,tm0 during acknowledge (1 = H)
  localparam logic [1:0] NBS_ST_DONE = 2'b00;
  localparam logic [1:0] NBS_ST_ERR = 2'b01;
  localparam logic [1:0] NBS_ST_TMO = 2'b10;
  localparam logic [1:0] NBS_ST_RETRY = 2'b11;
  // pin-level attention codes
  localparam logic [1:0] NBS_ATT_NULL = 2'b00;
  localparam logic [1:0] NBS_ATT_LOCK = 2'b10;
  // card window: slot space 0xfs00_0000, memory words at ad[5:2]
  localparam logic [3:0] NBS_SLOT_HI = 4'hf;
  localparam int NBS_MEM_WORDS = 16;
  localparam int NBS_NMRQ_SLOTS = 6;
  // system timeout, in bus clock periods
  localparam int NBS_TMO_PERIODS = 256;
  localparam logic [8:0] NBS_TMO_LAST = 9'(NBS_TMO_PERIODS - 1);
  localparam logic [8:0] NBS_CNT_START = 9'h002;
  localparam logic [31:0] NBS_RST_WORD = 32'h0000_0000;
  localparam logic [3:0] NBS_RST_WAIT = 4'h0;

  typedef struct packed {
    logic wr;
    logic [3:0] be;
    logic [3:0] idx;
    logic hit;
    logic bad;
  } nbs_req_t;

  typedef struct packed {
    logic [1:0] tm_n;
    logic ack_n;
    logic oe;
  } nbs_ack_t;
endpackage

// ===== verilog/nbs_slave.sv
// nbs_slave: slave card end of the single-transfer bus with a small word memory,
// host timeout stand-in, lock tracking, bus-error flag and interrupt gathering.
// assumes bus pins are already in the core clock domain; only the slot interrupt
// lines arrive asynchronously.
//
// Operation
// RULE1: read drives the whole word, so requested lanes and all others are determinate.
// RULE2: master starts with address and mode at R(1), releases them at R(2).
// RULE3: slave drives data, ack and status at R(n), releases them at R(n+1).
// RULE4: acknowledge lands at cycle n, two or later and before 256.
// RULE5: master switches lines to write data at R(2) and holds until ack.
// RULE6: master places byte and halfword write data on its own lanes.
// RULE7: slave captures write data together with its ack, once accepted.
// RULE8: master sees ack at F(n); ack and status released at R(n+1).
// RULE9: status codes: LL complete, LH error, HL timeout, HH try again.
// RULE10: error still ends the transaction normally; master handles it.
// RULE11: timeout logic acks with timeout status after 256 periods without ack.
// RULE12: try-again status is given only while retry is requested, so retries stay few.
// RULE13: host-owned access ending not complete raises a bus error pulse.
// RULE14: start plus ack is attention; LL null, HL lock, others reserved.
// RULE15: attention cycles ignore the address/data lines and move no data.
// RULE16: master uses attention-null to restart arbitration or end a lock.
// RULE17: attention-lock blocks local access until attention-null.
// RULE18: master drives ack unasserted in its start cycle.
// RULE19: master ends on first ack and latches nothing from a following attention.
// RULE20: start decoded only when start asserted and ack not asserted.
// RULE21: slot interrupt lines are ORed into one irq and readable one by one.
// RULE22: interrupt-by-write scheme is not used here.
// RULE23: mode from tm1,tm0 with ad1,ad0; tm1 low write, tm0 low byte.
// RULE24: unjustified lanes: byte k always on lane k.
// RULE25: start and ack are each one clock period long.
`timescale 1ns/1ps
module nbs_slave
  import nbs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_slot_id,
  input wire logic [3:0] i_wait,
  input wire logic i_retry,
  input wire logic i_tmo_en,
  input wire logic i_host_txn,
  input wire logic i_start_n,
  input wire logic i_ack_n,
  input wire logic [1:0] i_tm_n,
  input wire logic [31:0] i_ad_n,
  input wire logic [NBS_NMRQ_SLOTS-1:0] i_nmrq_n,
  output logic o_ack_n,
  output logic o_ack_oe,
  output logic [1:0] o_tm_n,
  output logic o_tm_oe,
  output logic [31:0] o_ad_n,
  output logic o_ad_oe,
  output logic o_lock_active,
  output logic o_bus_err,
  output logic o_nmrq_irq,
  output logic [NBS_NMRQ_SLOTS-1:0] o_nmrq_slots
);
  typedef enum logic [1:0] {NBS_IDLE, NBS_WAIT, NBS_ACK} nbs_state_t;

  nbs_state_t state_r, state_nxt;
  nbs_req_t req_r;
  logic [31:0] mem_r [NBS_MEM_WORDS];
  logic [3:0] wait_r;
  logic [8:0] cnt_r;
  logic busy_r;
  logic [NBS_NMRQ_SLOTS-1:0] sync1_r, sync2_r, sync3_r;

  // bus decode, pin levels turned to true address
  wire [31:0] ad = ~i_ad_n;
  wire start_cyc = !i_start_n && i_ack_n; // RULE20
  wire attn_cyc = !i_start_n && !i_ack_n; // RULE14 RULE15
  wire ack_cyc = i_start_n && !i_ack_n;
  wire att_null = attn_cyc && i_tm_n == NBS_ATT_NULL;
  wire att_lock = attn_cyc && i_tm_n == NBS_ATT_LOCK;
  wire is_wr = !i_tm_n[1]; // RULE23
  wire is_byte = !i_tm_n[0];
  wire [3:0] be_byte = 4'h1 << ad[1:0]; // RULE24
  wire [3:0] be_half = ad[1] ? 4'hc : 4'h3;
  wire is_block = ad[1:0] == 2'b10;
  wire [3:0] be_dec = is_byte ? be_byte : (ad[0] ? 4'h0 : (is_block ? 4'h0 : 4'hf));
  wire [3:0] be_sel = (!is_byte && !ad[0] && ad[1]) ? 4'h0 : be_dec;
  wire [3:0] be_now = (!is_byte && ad[0]) ? be_half : be_sel;
  wire hit = ad[31:28] == NBS_SLOT_HI && ad[27:24] == i_slot_id;
  wire bad = ad[23:6] != 18'h00000;
  nbs_req_t req_now;
  assign req_now = '{wr: is_wr, be: be_now, idx: ad[5:2], hit: hit, bad: bad};
  // block requests get a normal ack with their data ignored (empty byte enables)

  // a new start may land in the cycle right after our ack
  wire take = start_cyc && hit && (state_r == NBS_IDLE || state_r == NBS_ACK); // RULE3
  wire wait_done = wait_r == 4'h0;
  wire [1:0] st_now = req_r.bad ? NBS_ST_ERR : (i_retry ? NBS_ST_RETRY : NBS_ST_DONE); // RULE9 RULE12
  // data taken at the ack edge itself, before the master may reuse the lines
  wire write_en = state_r == NBS_WAIT && wait_done && req_r.wr
                  && st_now == NBS_ST_DONE; // RULE7
  // cnt_r runs one ahead of the bus cycle number; a late slave may still ack in cycle 255
  wire tmo_fire = i_tmo_en && busy_r && !ack_cyc && cnt_r == NBS_TMO_LAST + 9'h001
                  && state_r == NBS_IDLE; // RULE11

  nbs_ack_t drv;
  wire drv_oe = (state_r == NBS_WAIT && wait_done) || tmo_fire;
  assign drv = '{tm_n: (tmo_fire ? NBS_ST_TMO : st_now), ack_n: 1'b0, oe: drv_oe};
  wire [31:0] rd_word = mem_r[req_r.idx];
  wire rd_drive = drv.oe && !tmo_fire && !req_r.wr && st_now == NBS_ST_DONE;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      NBS_IDLE: if (take) state_nxt = NBS_WAIT; // RULE2
      NBS_WAIT: if (wait_done) state_nxt = NBS_ACK; // RULE4
      NBS_ACK: state_nxt = take ? NBS_WAIT : NBS_IDLE; // RULE25 RULE3
      default: state_nxt = NBS_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= NBS_IDLE;
      req_r <= '0;
      wait_r <= NBS_RST_WAIT;
    end else if (i_ce) begin
      state_r <= state_nxt;
      if (take) req_r <= req_now;
      if (take) wait_r <= i_wait;
      else if (state_r == NBS_WAIT && !wait_done) wait_r <= wait_r - 4'h1;
    end
  end

  // ack, status and data flops; one cycle only, then released
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_ack_n <= 1'b1;
      o_ack_oe <= 1'b0;
      o_tm_n <= NBS_ST_DONE;
      o_tm_oe <= 1'b0;
      o_ad_n <= 32'hffff_ffff;
      o_ad_oe <= 1'b0;
    end else if (i_ce) begin
      o_ack_n <= drv.oe ? drv.ack_n : 1'b1; // RULE3 RULE8
      o_ack_oe <= drv.oe;
      o_tm_n <= drv.oe ? drv.tm_n : NBS_ST_DONE; // RULE9
      o_tm_oe <= drv.oe;
      o_ad_n <= rd_drive ? ~rd_word : 32'hffff_ffff; // RULE1
      o_ad_oe <= drv.oe && !req_r.wr && !tmo_fire;
    end
  end

  // write data taken with the ack edge, so n=2 never catches the address
  genvar g;
  generate
    for (g = 0; g < NBS_MEM_WORDS; g++) begin : g_mem
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          mem_r[g] <= NBS_RST_WORD;
        end else if (i_ce && write_en && req_r.idx == 4'(g)) begin
          for (int b = 0; b < 4; b++) begin
            if (req_r.be[b]) mem_r[g][8*b +: 8] <= ad[8*b +: 8]; // RULE7 RULE24
          end
        end
      end
    end
  endgenerate

  // timeout watch: busy from start to any ack
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      busy_r <= 1'b0;
      cnt_r <= NBS_CNT_START;
    end else if (i_ce) begin
      if (start_cyc) begin
        busy_r <= 1'b1;
        cnt_r <= NBS_CNT_START;
      end else if (ack_cyc || tmo_fire) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 9'h001;
      end
    end
  end

  // lock tenure and host bus error
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_lock_active <= 1'b0;
      o_bus_err <= 1'b0;
    end else if (i_ce) begin
      if (att_lock) o_lock_active <= 1'b1; // RULE17
      else if (att_null) o_lock_active <= 1'b0; // RULE17
      o_bus_err <= ack_cyc && i_host_txn && i_tm_n != NBS_ST_DONE; // RULE13
    end
  end

  // slot interrupts are asynchronous: three flops, change taken when 2nd and 3rd agree
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      o_nmrq_slots <= '0;
      o_nmrq_irq <= 1'b0;
    end else if (i_ce) begin
      sync1_r <= ~i_nmrq_n;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int s = 0; s < NBS_NMRQ_SLOTS; s++) begin
        if (sync2_r[s] == sync3_r[s]) o_nmrq_slots[s] <= sync3_r[s]; // RULE21
      end
      o_nmrq_irq <= |(o_nmrq_slots & ~(sync2_r ^ sync3_r))
                    | |(sync3_r & ~(sync2_r ^ sync3_r)); // RULE21
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst || !i_ce);

  a_ack_one_cycle: assert property (!o_ack_n |=> o_ack_n) // RULE25
    else $error("ack held longer than one cycle");
  a_ack_not_early: assert property (take |=> o_ack_n) // RULE4
    else $error("ack in start cycle plus one");
  a_ack_after_wait: assert property (take && i_wait == 4'h0 |-> ##2 !o_ack_n) // RULE3
    else $error("zero-wait ack missing");
  a_tm_with_ack: assert property (o_tm_oe == !o_ack_n && o_ack_oe == !o_ack_n) // RULE8
    else $error("status drive not paired with ack");
  a_err_status: assert property (drv.oe && !tmo_fire && req_r.bad |=> o_tm_n == NBS_ST_ERR) // RULE9
    else $error("bad address not errored");
  a_tmo_status: assert property (tmo_fire |=> !o_ack_n && o_tm_n == NBS_ST_TMO) // RULE11
    else $error("timeout ack wrong");
  a_tmo_count: assert property (start_cyc && i_tmo_en ##1 (!ack_cyc && !start_cyc) [*8]
    |-> cnt_r == 9'h009) // RULE11
    else $error("timeout counter off");
  a_no_attn_take: assert property (attn_cyc |-> !take) // RULE20
    else $error("attention taken as start");
  a_lock_set: assert property (att_lock |=> o_lock_active) // RULE17
    else $error("lock not set");
  a_lock_clr: assert property (att_null |=> !o_lock_active) // RULE17
    else $error("lock not cleared");
  a_bus_err: assert property (ack_cyc && i_host_txn && i_tm_n == NBS_ST_RETRY |=> o_bus_err) // RULE13
    else $error("bus error missed");
  a_read_data: assert property (rd_drive |=> o_ad_oe && o_ad_n == ~$past(rd_word)) // RULE1
    else $error("read data not driven");

  c_read: cover property (take && !req_now.wr ##[1:17] !o_ack_n);
  c_write: cover property (take && req_now.wr ##[1:17] write_en);
  c_timeout: cover property (tmo_fire);
  c_lock: cover property (att_lock ##[1:50] att_null);
  c_back2back: cover property (take && state_r == NBS_ACK);
endmodule // nbs_slave
